//--- layered_trigger_sequencer_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "lts_defines.vh"
module layered_trigger_sequencer_tb_top;
  logic        clk_sys = 1'b0;
  logic        arst_n = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [4:0]  ev = 5'h00;
  logic        slow = 1'b0;
  int          fails = 0;
  int          n_checks = 0;
  int          n_close = 0;
  int          n_func = 0;
  int          seed = 32'hc50c;
  logic [31:0] exp_l[$];
  logic [31:0] msk_l[$];
  wire logic [31:0] avs_readdata;
  wire logic [15:0] n_adv;
  wire logic [7:0]  chan_sel;
  wire logic avs_waitrequest, meas_start, meas_done, seq_active_lamp;
  wire logic out_trig, chan_open, chan_close, func_change;
  always #12.5 clk_sys = ~clk_sys;
  lts_sequencer DUT (.clk_sys, .arst_n, .clk_en(1'b1), .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .fire_key(ev[0]),
    .bus_get(ev[1]), .ext_trig_in(ev[2]), .sync_line_in(ev[3]), .alarm_match(ev[4]),
    .meas_start, .meas_done, .seq_active_lamp, .out_trig, .chan_open, .chan_close, .chan_sel,
    .func_change);
  lts_meas_model u_meas (.clk_sys, .arst_n, .slow, .meas_start, .meas_done, .out_trig, .n_adv);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_l.push_back(e);
    msk_l.push_back(m);
    @(posedge clk_sys);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
  endtask
  // read data are judged where the bus hands them over
  always @(posedge clk_sys) begin
    if (avs_read && avs_waitrequest === 1'b0) chk(avs_readdata & msk_l.pop_front(), exp_l.pop_front());
    if (chan_close === 1'b1) n_close++;
    if (func_change === 1'b1) n_func++;
  end
  task automatic pulse(input int k);
    @(posedge clk_sys);
    ev <= 5'h01 << k;
    @(posedge clk_sys);
    ev <= 5'h00;
  endtask
  task automatic wait_adv(input logic [15:0] n, input int lim);
    int t = 0;
    while (n_adv < n && t < lim) begin
      @(posedge clk_sys);
      t++;
    end
  endtask
  task automatic to_idle;
    int t = 0;
    while (seq_active_lamp !== 1'b0 && t < 500) begin
      @(posedge clk_sys);
      t++;
    end
    chk({31'h0, seq_active_lamp}, 32'h0);
  endtask
  // one layer on one source; k picks the event, 9 is the trigger command
  task automatic src_case(input logic [3:0] r, input logic [2:0] s, input int k, input bit ok);
    logic [15:0] base;
    base = n_adv;
    wr(r, {16'h1, 13'h0, s});
    wr(`LTS_REG_CTRL, 32'h1);
    repeat (20) @(posedge clk_sys);
    if (k >= 0) chk({16'h0, n_adv}, {16'h0, base});
    if (k == 9) wr(`LTS_REG_CTRL, 32'h4);
    else if (k >= 0) pulse(k);
    wait_adv(base + 16'h1, 200);
    chk({16'h0, n_adv}, {16'h0, base + 16'(ok)});
    if (!ok) wr(`LTS_REG_CTRL, 32'h2);
    wr(r, 32'h0001_0000);
    to_idle();
  endtask
  initial begin
    logic [15:0] ca, cs, cm, base;
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    for (int i = 1; i < 4; i++) rd(i[3:0], 32'h0001_0000, 32'hffff_ffff);
    rd(`LTS_REG_TIMER, 32'h0000_0064, 32'hffff_ffff);
    rd(`LTS_REG_ACTION, 32'h0000_0400, 32'hffff_ffff);
    wr(4'hc, 32'hffff_ffff);
    rd(4'hc, 32'h0, 32'hffff_ffff);
    rd(`LTS_REG_STATUS, 32'h0, 32'hf);
    // start by key onto a held measure layer
    wr(`LTS_REG_MEAS_CFG, {16'h1, 13'h0, `LTS_SRC_HOLD});
    pulse(0);
    repeat (60) @(posedge clk_sys);
    chk({31'h0, seq_active_lamp}, 32'h1);
    chk({16'h0, n_adv}, 32'h0);
    rd(`LTS_REG_STATUS, 32'h3, 32'hf);
    wr(`LTS_REG_CTRL, 32'h2);
    to_idle();
    src_case(`LTS_REG_MEAS_CFG, `LTS_SRC_IMM, -1, 1);
    src_case(`LTS_REG_MEAS_CFG, `LTS_SRC_MANUAL, 0, 1);
    src_case(`LTS_REG_MEAS_CFG, `LTS_SRC_BUS, 1, 1);
    src_case(`LTS_REG_SCAN_CFG, `LTS_SRC_BUS, 9, 1);
    src_case(`LTS_REG_MEAS_CFG, `LTS_SRC_EXT, 2, 1);
    src_case(`LTS_REG_SCAN_CFG, `LTS_SRC_SYNC, 3, 1);
    src_case(`LTS_REG_MEAS_CFG, `LTS_SRC_ALARM, 4, 0);
    src_case(`LTS_REG_ARM_CFG, `LTS_SRC_ALARM, 4, 1);
    src_case(`LTS_REG_MEAS_CFG, `LTS_SRC_TIMER, -1, 1);
    src_case(`LTS_REG_ARM_CFG, `LTS_SRC_TIMER, -1, 0);
    // timer: first pass free, second waits the interval
    base = n_adv;
    wr(`LTS_REG_TIMER, 32'h0000_001e);
    wr(`LTS_REG_MEAS_CFG, {16'h2, 13'h0, `LTS_SRC_TIMER});
    wr(`LTS_REG_CTRL, 32'h1);
    wait_adv(base + 16'h1, 12);
    repeat (20) @(posedge clk_sys);
    chk({16'h0, n_adv}, {16'h0, base + 16'h1});
    wait_adv(base + 16'h2, 40);
    chk({16'h0, n_adv}, {16'h0, base + 16'h2});
    to_idle();
    // nested loop counts, random per layer, prompt and slow engine
    for (int i = 0; i < 3; i++) begin
      ca = 16'(($random(seed) & 3) + 1);
      cs = 16'(($random(seed) & 3) + 1);
      cm = 16'(($random(seed) & 3) + 1);
      slow <= i[0];
      base = n_adv;
      wr(`LTS_REG_ARM_CFG, {ca, 16'h0});
      wr(`LTS_REG_SCAN_CFG, {cs, 16'h0});
      wr(`LTS_REG_MEAS_CFG, {cm, 16'h0});
      wr(`LTS_REG_CTRL, 32'h1);
      wait_adv(base + ca * cs * cm, 3000);
      chk({16'h0, n_adv}, {16'h0, base + ca * cs * cm});
      to_idle();
    end
    // scan with function change, three channels, four readings
    wr(`LTS_REG_ARM_CFG, `LTS_CFG_RST);
    wr(`LTS_REG_SCAN_CFG, `LTS_CFG_RST);
    base = n_adv;
    n_close = 0;
    n_func = 0;
    wr(`LTS_REG_ACTION, 32'h0000_0303);
    wr(`LTS_REG_MEAS_CFG, 32'h0004_0000);
    wr(`LTS_REG_CTRL, 32'h1);
    wait_adv(base + 16'h4, 2000);
    chk({16'h0, n_adv}, {16'h0, base + 16'h4});
    chk(n_close, 32'h4);
    chk(n_func, 32'h4);
    chk({24'h0, chan_sel}, 32'h1);
    to_idle();
    wr(`LTS_REG_ACTION, 32'h0000_0400);
    // bench default runs on without end
    base = n_adv;
    wr(`LTS_REG_CTRL, 32'h8);
    repeat (400) @(posedge clk_sys);
    chk({31'h0, seq_active_lamp}, 32'h1);
    chk({31'h0, n_adv - base > 16'h14}, 32'h1);
    wr(`LTS_REG_CTRL, 32'h2);
    to_idle();
    complete_run();
  end
  initial begin
    repeat (60000) @(posedge clk_sys);
    fails++;
    complete_run();
  end
endmodule
`default_nettype wire

//--- lts_defines.vh
// Operation
// - sequence-active lamp stays dark whenever the sequencer is idle.
// - fire key or bus initiate leaves idle, lights lamp, enters arm layer.
// - three nested layers arm, scan, measure descend to the device action.
// - each layer waits at its source point until its selected event occurs.
// - immediate source is satisfied at once.
// - manual source is satisfied only by the fire key.
// - bus source proceeds on group-execute-trigger or trigger command.
// - calendar alarm source, arm layer only, fires at programmed date and time.
// - interval timer, not in arm layer, passes first, then waits interval.
// - external source proceeds on external trigger input pulse.
// - shared sync line source proceeds on trigger from the link.
// - hold source is never satisfied, operation stalls.
// - action is measurement, optional function change and channel scan first.
// - internal channel stepping opens previous channel before closing next.
// - relay settling delay follows channel close before measuring.
// - one output trigger pulse after every completed device action.
// - each layer has a loop counter; infinite keeps measure layer looping.
// - after each action return to measure wait point unless counter exhausted.
// - a layer counter resets when operation leaves to a higher layer or idle.
// - bench default: out of idle, all immediate, measure counter infinite.
`ifndef LTS_DEFINES_VH
`define LTS_DEFINES_VH

// register word addresses
`define LTS_REG_CTRL      4'h0
`define LTS_REG_ARM_CFG   4'h1
`define LTS_REG_SCAN_CFG  4'h2
`define LTS_REG_MEAS_CFG  4'h3
`define LTS_REG_TIMER     4'h4
`define LTS_REG_ACTION    4'h5
`define LTS_REG_STATUS    4'h6
`define LTS_REG_ALARM     4'h7

// ctrl fields
`define LTS_CTRL_INIT     0
`define LTS_CTRL_ABORT    1
`define LTS_CTRL_TRG      2
`define LTS_CTRL_DEFAULT  3

// layer cfg fields: src [2:0], infinite [3], count [31:16]
`define LTS_CFG_SRC_LSB   0
`define LTS_CFG_INF_BIT   3
`define LTS_CFG_CNT_LSB   16

// action fields
`define LTS_ACT_SCAN_EN   0
`define LTS_ACT_FUNC_CHG  1
`define LTS_ACT_NCHAN_LSB 8

// control sources
`define LTS_SRC_IMM       3'h0
`define LTS_SRC_MANUAL    3'h1
`define LTS_SRC_BUS       3'h2
`define LTS_SRC_ALARM     3'h3
`define LTS_SRC_TIMER     3'h4
`define LTS_SRC_EXT       3'h5
`define LTS_SRC_SYNC      3'h6
`define LTS_SRC_HOLD      3'h7

// reset values
`define LTS_CFG_RST       32'h0001_0000
`define LTS_TIMER_RST     32'h0000_0064
`define LTS_ACT_RST       32'h0000_0400

// timing: relay settle in ns, cycles at 25 ns, rounded up
`define LTS_CLK_NS        25
`define LTS_SETTLE_NS     1000
`define LTS_SETTLE_CYC    ((`LTS_SETTLE_NS + `LTS_CLK_NS - 1) / `LTS_CLK_NS)
`define LTS_FUNC_CYC      8
`define LTS_BREAK_CYC     4

`endif

//--- lts_meas_model.sv
`timescale 1ns/100ps
`default_nettype none
module lts_meas_model (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // measurement engine
  input  wire logic        slow,
  input  wire logic        meas_start,
  output var  logic        meas_done,
  // external scanner
  input  wire logic        out_trig,
  output var  logic [15:0] n_adv
);
  logic [3:0] wait_q;
  logic       busy_q;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      busy_q    <= 1'b0;
      wait_q    <= 4'h0;
      meas_done <= 1'b0;
      n_adv     <= 16'h0;
    end else begin
      meas_done <= 1'b0;
      if (meas_start) begin
        busy_q <= 1'b1;
        wait_q <= slow ? 4'h9 : 4'h0;
      end else if (busy_q && wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end else if (busy_q) begin
        busy_q    <= 1'b0;
        meas_done <= 1'b1;
      end
      // scanner steps one channel per output pulse
      if (out_trig) n_adv <= n_adv + 16'h1;
    end
  end
endmodule
`default_nettype wire

//--- lts_seq_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module lts_seq_asserts (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // bus handshake
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // sequencer pins
  input wire logic clk_en,
  input wire logic fire_key,
  input wire logic meas_start,
  input wire logic meas_done,
  input wire logic seq_active_lamp,
  input wire logic out_trig,
  input wire logic chan_open,
  input wire logic chan_close
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // saturating so a long idle stretch cannot wrap into a false failure
  logic [7:0] since_q;
  logic       pend_q;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      since_q <= 8'h00;
      pend_q  <= 1'b0;
    end else begin
      if (chan_close) since_q <= 8'h00;
      else if (since_q != 8'hff) since_q <= since_q + 8'h01;
      if (chan_close) pend_q <= 1'b1;
      else if (meas_start) pend_q <= 1'b0;
    end
  end
  idle_quiet_a: assert property (
    !seq_active_lamp |-> !meas_start && !chan_open && !chan_close)
    else $error("action while idle");
  start_lamp_a: assert property (
    clk_en && fire_key && !seq_active_lamp |=> seq_active_lamp)
    else $error("fire key did not start");
  done_trig_a: assert property (
    out_trig |-> $past(meas_done))
    else $error("output pulse without completion");
  trig_once_a: assert property (
    out_trig |=> !out_trig)
    else $error("output pulse too long");
  start_pulse_a: assert property (
    meas_start |=> !meas_start)
    else $error("start pulse too long");
  break_make_a: assert property (
    chan_open |=> !chan_close [*4])
    else $error("close too soon after open");
  settle_time_a: assert property (
    meas_start && pend_q |-> since_q >= 8'h28)
    else $error("relay settle too short");
  read_wait_a: assert property (
    $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read wait cycle wrong");
  write_nowait_a: assert property (
    avs_write && clk_en |-> !avs_waitrequest)
    else $error("write stalled");
endmodule
bind lts_sequencer lts_seq_asserts u_chk (
  .clk_sys, .arst_n, .avs_read, .avs_write, .avs_waitrequest, .clk_en, .fire_key,
  .meas_start, .meas_done, .seq_active_lamp, .out_trig, .chan_open, .chan_close);
`default_nettype wire

//--- lts_sequencer.v
// Chosen here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "lts_defines.vh"

module lts_sequencer (
  // clock and reset
  input  wire        clk_sys,
  input  wire        arst_n,
  input  wire        clk_en,
  // avalon-mm slave
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // trigger event inputs
  input  wire        fire_key,
  input  wire        bus_get,
  input  wire        ext_trig_in,
  input  wire        sync_line_in,
  input  wire        alarm_match,
  // measurement engine
  output reg         meas_start,
  input  wire        meas_done,
  // outputs
  output reg         seq_active_lamp,
  output reg         out_trig,
  output reg         chan_open,
  output reg         chan_close,
  output reg  [7:0]  chan_sel,
  output reg         func_change
);

  // states, binary coded; unused codes fall back to idle
  localparam [3:0] ST_IDLE   = 4'h0;
  localparam [3:0] ST_ARM    = 4'h1;
  localparam [3:0] ST_SCAN   = 4'h2;
  localparam [3:0] ST_MEAS   = 4'h3;
  localparam [3:0] ST_FUNC   = 4'h4;
  localparam [3:0] ST_OPEN   = 4'h5;
  localparam [3:0] ST_CLOSE  = 4'h6;
  localparam [3:0] ST_SETTLE = 4'h7;
  localparam [3:0] ST_RUN    = 4'h8;
  localparam [3:0] ST_WAITM  = 4'h9;
  localparam [3:0] ST_DONE   = 4'ha;

  // delays counted in cycles of clk_sys
  localparam [15:0] SETTLE_CYC = `LTS_SETTLE_CYC;
  localparam [15:0] FUNC_CYC   = `LTS_FUNC_CYC;
  localparam [15:0] BREAK_CYC  = `LTS_BREAK_CYC;

  reg [3:0]  st_q;
  reg [31:0] arm_cfg_q;
  reg [31:0] scan_cfg_q;
  reg [31:0] meas_cfg_q;
  reg [31:0] timer_q;
  reg [31:0] act_q;
  reg [15:0] arm_cnt_q;
  reg [15:0] scan_cnt_q;
  reg [15:0] meas_cnt_q;
  reg [31:0] scan_tmr_q;
  reg [31:0] meas_tmr_q;
  // first-pass flags let an interval-timer layer pass at once on entry
  reg        scan_first_q;
  reg        meas_first_q;
  reg [15:0] dly_q;
  reg        rd_pend_q;
  reg        bus_trg_q;
  reg        init_q;

  // one-cycle read latency, writes take at once; a frozen clock stalls
  // every request, since a write accepted then would be lost
  assign avs_waitrequest = ~clk_en | (avs_read & ~rd_pend_q);

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  be;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  // event condition of one layer
  function ev_met;
    input [2:0] src;
    input       allow_alarm;
    input       allow_timer;
    input       first;
    input       tmr_zero;
    input       key;
    input       btrg;
    input       ext;
    input       sync;
    input       alarm;
    begin
      case (src)
        `LTS_SRC_IMM:    ev_met = 1'b1;
        `LTS_SRC_MANUAL: ev_met = key;
        `LTS_SRC_BUS:    ev_met = btrg;
        `LTS_SRC_ALARM:  ev_met = allow_alarm & alarm;
        `LTS_SRC_TIMER:  ev_met = allow_timer & (first | tmr_zero);
        `LTS_SRC_EXT:    ev_met = ext;
        `LTS_SRC_SYNC:   ev_met = sync;
        default:         ev_met = 1'b0;
      endcase
    end
  endfunction

  // control source field of a layer configuration
  function [2:0] src_of;
    input [31:0] cfg;
    begin
      src_of = cfg[`LTS_CFG_SRC_LSB +: 3];
    end
  endfunction

  // layer exhausted after count passes unless infinite
  function exhausted;
    input [31:0] cfg;
    input [15:0] cnt;
    begin
      exhausted = ~cfg[`LTS_CFG_INF_BIT] &
                  (cnt + 16'h0001 >= cfg[`LTS_CFG_CNT_LSB +: 16]);
    end
  endfunction

  wire wr_ctrl = avs_write & (avs_address == `LTS_REG_CTRL);
  wire start_req = fire_key | (wr_ctrl & avs_writedata[`LTS_CTRL_INIT]) | init_q;
  wire abort_req = wr_ctrl & avs_writedata[`LTS_CTRL_ABORT];
  wire trg_set   = wr_ctrl & avs_writedata[`LTS_CTRL_TRG];
  wire bus_trig  = bus_get | bus_trg_q;
  // a latched bus trigger is spent by whichever layer is waiting
  wire in_wait   = (st_q == ST_ARM) | (st_q == ST_SCAN) | (st_q == ST_MEAS);

  wire arm_ok  = ev_met(src_of(arm_cfg_q), 1'b1, 1'b0, 1'b0, 1'b0,
                        fire_key, bus_trig, ext_trig_in, sync_line_in, alarm_match);
  wire scan_ok = ev_met(src_of(scan_cfg_q), 1'b0, 1'b1, scan_first_q, scan_tmr_q == 32'h0,
                        fire_key, bus_trig, ext_trig_in, sync_line_in, alarm_match);
  wire meas_ok = ev_met(src_of(meas_cfg_q), 1'b0, 1'b1, meas_first_q, meas_tmr_q == 32'h0,
                        fire_key, bus_trig, ext_trig_in, sync_line_in, alarm_match);

  wire [7:0] nchan = act_q[`LTS_ACT_NCHAN_LSB +: 8];
  wire       scan_en = act_q[`LTS_ACT_SCAN_EN];
  wire       func_en = act_q[`LTS_ACT_FUNC_CHG];
  // next channel, wrapping at the programmed channel count
  wire [7:0] chan_nxt = (chan_sel + 8'h01 >= nchan) ? 8'h00 : chan_sel + 8'h01;

  // loop decision of each layer once an action has completed
  wire meas_exh = exhausted(meas_cfg_q, meas_cnt_q);
  wire scan_exh = exhausted(scan_cfg_q, scan_cnt_q);
  wire arm_exh  = exhausted(arm_cfg_q, arm_cnt_q);

  // status snapshot: state, low counter bits, present channel
  wire [31:0] status_w = {chan_sel, meas_cnt_q[7:0], scan_cnt_q[7:0],
                          arm_cnt_q[3:0], st_q};

  // register bus
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      arm_cfg_q    <= `LTS_CFG_RST;
      scan_cfg_q   <= `LTS_CFG_RST;
      meas_cfg_q   <= `LTS_CFG_RST;
      timer_q      <= `LTS_TIMER_RST;
      act_q        <= `LTS_ACT_RST;
      rd_pend_q    <= 1'b0;
      avs_readdata <= 32'h0;
      init_q       <= 1'b0;
    end else if (clk_en) begin
      rd_pend_q <= avs_read & ~rd_pend_q;
      init_q    <= 1'b0;
      // read data captured on the first cycle of the read
      if (avs_read & ~rd_pend_q) begin
        case (avs_address)
          `LTS_REG_ARM_CFG:  avs_readdata <= arm_cfg_q;
          `LTS_REG_SCAN_CFG: avs_readdata <= scan_cfg_q;
          `LTS_REG_MEAS_CFG: avs_readdata <= meas_cfg_q;
          `LTS_REG_TIMER:    avs_readdata <= timer_q;
          `LTS_REG_ACTION:   avs_readdata <= act_q;
          `LTS_REG_STATUS:   avs_readdata <= status_w;
          default:           avs_readdata <= 32'h0;
        endcase
      end
      if (avs_write) begin
        case (avs_address)
          `LTS_REG_ARM_CFG:  arm_cfg_q  <= merge(arm_cfg_q, avs_writedata, avs_byteenable);
          `LTS_REG_SCAN_CFG: scan_cfg_q <= merge(scan_cfg_q, avs_writedata, avs_byteenable);
          `LTS_REG_MEAS_CFG: meas_cfg_q <= merge(meas_cfg_q, avs_writedata, avs_byteenable);
          `LTS_REG_TIMER:    timer_q    <= merge(timer_q, avs_writedata, avs_byteenable);
          `LTS_REG_ACTION:   act_q      <= merge(act_q, avs_writedata, avs_byteenable);
          `LTS_REG_CTRL: begin
            if (avs_writedata[`LTS_CTRL_DEFAULT]) begin
              // bench default setup
              arm_cfg_q  <= `LTS_CFG_RST;
              scan_cfg_q <= `LTS_CFG_RST;
              meas_cfg_q <= `LTS_CFG_RST | (32'h1 << `LTS_CFG_INF_BIT);
              init_q     <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // sequencer
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_q            <= ST_IDLE;
      arm_cnt_q       <= 16'h0;
      scan_cnt_q      <= 16'h0;
      meas_cnt_q      <= 16'h0;
      scan_tmr_q      <= 32'h0;
      meas_tmr_q      <= 32'h0;
      scan_first_q    <= 1'b1;
      meas_first_q    <= 1'b1;
      dly_q           <= 16'h0;
      bus_trg_q       <= 1'b0;
      seq_active_lamp <= 1'b0;
      out_trig        <= 1'b0;
      meas_start      <= 1'b0;
      chan_open       <= 1'b0;
      chan_close      <= 1'b0;
      chan_sel        <= 8'h0;
      func_change     <= 1'b0;
    end else if (clk_en) begin
      out_trig    <= 1'b0;
      meas_start  <= 1'b0;
      chan_open   <= 1'b0;
      chan_close  <= 1'b0;
      func_change <= 1'b0;
      if (dly_q != 16'h0)
        dly_q <= dly_q - 16'h0001;
      // interval timers run down freely; each pass reloads its own
      if (scan_tmr_q != 32'h0)
        scan_tmr_q <= scan_tmr_q - 32'h1;
      if (meas_tmr_q != 32'h0)
        meas_tmr_q <= meas_tmr_q - 32'h1;
      // bus trigger held until a layer consumes it; set wins over consume
      if (trg_set)
        bus_trg_q <= 1'b1;
      else if (in_wait)
        bus_trg_q <= 1'b0;
      // abort leaves any layer at once; counters restart from zero
      if (abort_req) begin
        st_q            <= ST_IDLE;
        seq_active_lamp <= 1'b0;
        arm_cnt_q       <= 16'h0;
        scan_cnt_q      <= 16'h0;
        meas_cnt_q      <= 16'h0;
        scan_first_q    <= 1'b1;
        meas_first_q    <= 1'b1;
      end else begin
        case (st_q)
          ST_IDLE: begin
            // lamp forced dark every idle cycle, whatever came before
            seq_active_lamp <= 1'b0;
            if (start_req) begin
              st_q            <= ST_ARM;
              seq_active_lamp <= 1'b1;
            end
          end
          ST_ARM: begin
            if (arm_ok)
              st_q <= ST_SCAN;
          end
          ST_SCAN: begin
            if (scan_ok) begin
              st_q         <= ST_MEAS;
              scan_first_q <= 1'b0;
              scan_tmr_q   <= timer_q;
            end
          end
          ST_MEAS: begin
            if (meas_ok) begin
              meas_first_q <= 1'b0;
              meas_tmr_q   <= timer_q;
              // function change, then channel step, then measurement
              if (func_en) begin
                st_q        <= ST_FUNC;
                func_change <= 1'b1;
                dly_q       <= FUNC_CYC;
              end else if (scan_en) begin
                st_q      <= ST_OPEN;
                chan_open <= 1'b1;
                dly_q     <= BREAK_CYC;
              end else begin
                st_q       <= ST_RUN;
                meas_start <= 1'b1;
              end
            end
          end
          ST_FUNC: begin
            if (dly_q == 16'h0) begin
              if (scan_en) begin
                st_q      <= ST_OPEN;
                chan_open <= 1'b1;
                dly_q     <= BREAK_CYC;
              end else begin
                st_q       <= ST_RUN;
                meas_start <= 1'b1;
              end
            end
          end
          ST_OPEN: begin
            // previous channel fully open before the next is closed
            if (dly_q == 16'h0) begin
              st_q       <= ST_CLOSE;
              chan_sel   <= chan_nxt;
            end
          end
          ST_CLOSE: begin
            // relay closes now; settling is counted from this pulse
            st_q       <= ST_SETTLE;
            chan_close <= 1'b1;
            dly_q      <= SETTLE_CYC;
          end
          ST_SETTLE: begin
            if (dly_q == 16'h0) begin
              st_q       <= ST_RUN;
              meas_start <= 1'b1;
            end
          end
          ST_RUN: begin
            // start pulse is out this cycle; the engine answers later
            st_q <= ST_WAITM;
          end
          ST_WAITM: begin
            // no timeout: a stalled engine holds here until an abort
            if (meas_done) begin
              st_q     <= ST_DONE;
              out_trig <= 1'b1;
            end
          end
          ST_DONE: begin
            // innermost layer decides first; an exhausted one hands up
            if (!meas_exh) begin
              st_q       <= ST_MEAS;
              meas_cnt_q <= meas_cnt_q + 16'h0001;
            end else begin
              meas_cnt_q   <= 16'h0;
              meas_first_q <= 1'b1;
              if (!scan_exh) begin
                st_q       <= ST_SCAN;
                scan_cnt_q <= scan_cnt_q + 16'h0001;
              end else begin
                scan_cnt_q   <= 16'h0;
                scan_first_q <= 1'b1;
                if (!arm_exh) begin
                  st_q      <= ST_ARM;
                  arm_cnt_q <= arm_cnt_q + 16'h0001;
                end else begin
                  st_q            <= ST_IDLE;
                  arm_cnt_q       <= 16'h0;
                  seq_active_lamp <= 1'b0;
                end
              end
            end
          end
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end

endmodule
`default_nettype wire
